// [rtl/sram_host_ctrl.sv]
`timescale 1ns/100ps
module sram_host_ctrl #(
   parameter bit FAST_GRADE = 1'b1
) (
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   input  wire logic                               ce_i,
   input  wire logic                               req_i,
   input  wire logic                               req_write_i,
   input  wire logic [sram_timing_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic [sram_timing_pkg::DATA_W-1:0] req_wdata_i,
   output logic                                    ready_o,
   output logic                                    done_o,
   output logic                                    rvalid_o,
   output logic [sram_timing_pkg::DATA_W-1:0]      rdata_o,
   output logic [sram_timing_pkg::ADDR_W-1:0]      word_address_o,
   output logic                                    chip_sel_n_o,
   output logic                                    out_en_n_o,
   output logic                                    write_en_n_o,
   output logic [sram_timing_pkg::DATA_W-1:0]      shared_data_bus_o,
   output logic                                    shared_data_bus_oe_o,
   input  wire logic [sram_timing_pkg::DATA_W-1:0] shared_data_bus_i
);

   // -------------------------------------------------------------------------
   // Grade dependent cycle counts
   // -------------------------------------------------------------------------
   localparam int CW = sram_timing_pkg::CNT_W;
   localparam int RD_TOTAL = (FAST_GRADE ? sram_timing_pkg::READ_CYC_F
                                         : sram_timing_pkg::READ_CYC_S)
                             + sram_timing_pkg::SYNC_STAGES;
   localparam logic [CW-1:0] RD_LOAD    = CW'(RD_TOTAL - 1);
   localparam logic [CW-1:0] PULSE_LOAD = CW'((FAST_GRADE ? sram_timing_pkg::PULSE_CYC_F
                                         : sram_timing_pkg::PULSE_CYC_S) - 1);
   localparam logic [CW-1:0] REC_LOAD   = CW'((FAST_GRADE ? sram_timing_pkg::REC_CYC_F
                                         : sram_timing_pkg::REC_CYC_S) - 1);
   localparam logic [CW-1:0] FLOAT_LOAD = CW'((FAST_GRADE ? sram_timing_pkg::FLOAT_CYC_F
                                         : sram_timing_pkg::FLOAT_CYC_S) - 1);

   // -------------------------------------------------------------------------
   // State machine
   // -------------------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE    = 5'b00001,
      ST_RD_WAIT = 5'b00010,
      ST_TURN    = 5'b00100,
      ST_WR_PULS = 5'b01000,
      ST_WR_REC  = 5'b10000
   } state_t;

   state_t                               state;
   state_t                               next_state;
   logic                                 tmr_load;
   logic [CW-1:0]                        tmr_count;
   logic                                 tmr_expired;
   logic [sram_timing_pkg::DATA_W-1:0]   bus_meta;
   logic [sram_timing_pkg::DATA_W-1:0]   bus_sync;

   wait_timer #(
      .CNT_W     (CW)
   ) u_timer (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .expired_o (tmr_expired)
   );

   always_comb begin
      next_state = state;
      tmr_load   = 1'b0;
      tmr_count  = '0;
      case (state)
         ST_IDLE: begin
            if (req_i) begin
               tmr_load   = 1'b1;
               next_state = req_write_i ? ST_WR_PULS : ST_RD_WAIT;
               tmr_count  = req_write_i ? PULSE_LOAD : RD_LOAD;
            end
         end
         ST_RD_WAIT: begin
            if (tmr_expired) begin
               tmr_load   = 1'b1;
               tmr_count  = FLOAT_LOAD;
               next_state = ST_TURN;
            end
         end
         ST_TURN: begin
            if (tmr_expired) begin
               next_state = ST_IDLE;
            end
         end
         ST_WR_PULS: begin
            if (tmr_expired) begin
               tmr_load   = 1'b1;
               tmr_count  = REC_LOAD;
               next_state = ST_WR_REC;
            end
         end
         ST_WR_REC: begin
            if (tmr_expired) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         ready_o <= 1'b0;
      end else if (ce_i) begin
         state   <= next_state;
         ready_o <= (next_state == ST_IDLE);
      end
   end

   // -------------------------------------------------------------------------
   // Read data synchroniser
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_meta <= '0;
         bus_sync <= '0;
      end else if (ce_i) begin
         bus_meta <= shared_data_bus_i;
         bus_sync <= bus_meta;
      end
   end

   // -------------------------------------------------------------------------
   // Memory pins
   // -------------------------------------------------------------------------
   // Output enable stays high for writes, so the memory never drives during
   // them; the stretched pulse still covers the oe-low case.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_address_o       <= '0;
         chip_sel_n_o         <= 1'b1;
         out_en_n_o           <= 1'b1;
         write_en_n_o         <= 1'b1;
         shared_data_bus_o    <= '0;
         shared_data_bus_oe_o <= 1'b0;
      end else if (ce_i) begin
         case (state)
            ST_IDLE: begin
               if (req_i) begin
                  word_address_o <= req_addr_i;
                  chip_sel_n_o   <= 1'b0;
                  out_en_n_o     <= req_write_i;
                  write_en_n_o   <= ~req_write_i;
                  if (req_write_i) begin
                     shared_data_bus_o    <= req_wdata_i;
                     shared_data_bus_oe_o <= 1'b1;
                  end
               end
            end
            ST_RD_WAIT: begin
               if (tmr_expired) begin
                  chip_sel_n_o <= 1'b1;
                  out_en_n_o   <= 1'b1;
               end
            end
            ST_WR_PULS: begin
               if (tmr_expired) begin
                  chip_sel_n_o <= 1'b1;
                  write_en_n_o <= 1'b1;
               end
            end
            ST_WR_REC: begin
               if (tmr_expired) begin
                  shared_data_bus_oe_o <= 1'b0;
               end
            end
            default: begin
               chip_sel_n_o <= 1'b1;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // User answers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o  <= '0;
         rvalid_o <= 1'b0;
         done_o   <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= 1'b0;
         done_o   <= 1'b0;
         if (state == ST_RD_WAIT && tmr_expired) begin
            rdata_o  <= bus_sync;
            rvalid_o <= 1'b1;
         end
         if ((state == ST_TURN || state == ST_WR_REC) && tmr_expired) begin
            done_o <= 1'b1;
         end
      end
   end

endmodule : sram_host_ctrl

// [rtl/sram_timing_pkg.sv]
package sram_timing_pkg;

   // -------------------------------------------------------------------------
   // Clock, pin and counter widths, sync stages
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int ADDR_W        = 19;
   localparam int DATA_W        = 8;
   localparam int CNT_W         = 8;
   localparam int SYNC_STAGES   = 2;

   // -------------------------------------------------------------------------
   // Limits in ns, fast grade then slow grade
   // -------------------------------------------------------------------------
   localparam int READ_CYCLE_MIN_F_NS           = 55;
   localparam int READ_CYCLE_MIN_S_NS           = 70;
   localparam int DESELECT_TO_FLOAT_MAX_F_NS    = 20;
   localparam int DESELECT_TO_FLOAT_MAX_S_NS    = 25;
   localparam int WRITE_CYCLE_MIN_F_NS          = 55;
   localparam int WRITE_CYCLE_MIN_S_NS          = 70;
   localparam int SELECT_TO_WRITE_END_MIN_F_NS  = 50;
   localparam int SELECT_TO_WRITE_END_MIN_S_NS  = 60;
   localparam int ADDRESS_TO_WRITE_END_MIN_F_NS = 50;
   localparam int ADDRESS_TO_WRITE_END_MIN_S_NS = 60;
   localparam int WRITE_PULSE_MIN_F_NS          = 40;
   localparam int WRITE_PULSE_MIN_S_NS          = 50;
   localparam int WRITE_TO_FLOAT_MAX_F_NS       = 20;
   localparam int WRITE_TO_FLOAT_MAX_S_NS       = 25;
   localparam int DATA_OVERLAP_MIN_F_NS         = 25;
   localparam int DATA_OVERLAP_MIN_S_NS         = 30;

   // -------------------------------------------------------------------------
   // Conversion helpers
   // -------------------------------------------------------------------------
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cycles

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : max2

   // -------------------------------------------------------------------------
   // Cycle counts
   // -------------------------------------------------------------------------
   localparam int READ_CYC_F  = ns_to_cycles(READ_CYCLE_MIN_F_NS);
   localparam int READ_CYC_S  = ns_to_cycles(READ_CYCLE_MIN_S_NS);
   localparam int FLOAT_CYC_F = ns_to_cycles(DESELECT_TO_FLOAT_MAX_F_NS);
   localparam int FLOAT_CYC_S = ns_to_cycles(DESELECT_TO_FLOAT_MAX_S_NS);
   localparam int PULSE_CYC_F = ns_to_cycles(max2(max2(WRITE_PULSE_MIN_F_NS,
      DATA_OVERLAP_MIN_F_NS + WRITE_TO_FLOAT_MAX_F_NS),
      max2(SELECT_TO_WRITE_END_MIN_F_NS, ADDRESS_TO_WRITE_END_MIN_F_NS)));
   localparam int PULSE_CYC_S = ns_to_cycles(max2(max2(WRITE_PULSE_MIN_S_NS,
      DATA_OVERLAP_MIN_S_NS + WRITE_TO_FLOAT_MAX_S_NS),
      max2(SELECT_TO_WRITE_END_MIN_S_NS, ADDRESS_TO_WRITE_END_MIN_S_NS)));
   localparam int REC_CYC_F   = max2(1, ns_to_cycles(WRITE_CYCLE_MIN_F_NS) - PULSE_CYC_F);
   localparam int REC_CYC_S   = max2(1, ns_to_cycles(WRITE_CYCLE_MIN_S_NS) - PULSE_CYC_S);

endpackage : sram_timing_pkg

// [rtl/wait_timer.sv]
`timescale 1ns/100ps
module wait_timer #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] count_i,
   output logic                  expired_o
);

   logic [CNT_W-1:0] remaining;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remaining <= '0;
      end else if (ce_i) begin
         if (load_i) begin
            remaining <= count_i;
         end else if (remaining != '0) begin
            remaining <= remaining - 1'b1;
         end
      end
   end

   assign expired_o = (remaining == '0);

endmodule : wait_timer

// [test/sram_host_ctrl_chk.sv]
`timescale 1ns/100ps
module sram_host_ctrl_chk #(
   parameter bit FAST_GRADE = 1'b1
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        req_i,
   input wire logic        req_write_i,
   input wire logic [18:0] req_addr_i,
   input wire logic [7:0]  req_wdata_i,
   input wire logic        ready_o,
   input wire logic        done_o,
   input wire logic        rvalid_o,
   input wire logic [18:0] word_address_o,
   input wire logic        chip_sel_n_o,
   input wire logic        out_en_n_o,
   input wire logic        write_en_n_o,
   input wire logic [7:0]  shared_data_bus_o,
   input wire logic        shared_data_bus_oe_o
);
   localparam int PULSE = FAST_GRADE ? sram_timing_pkg::PULSE_CYC_F : sram_timing_pkg::PULSE_CYC_S;
   localparam int WR_DONE = PULSE + (FAST_GRADE ? sram_timing_pkg::REC_CYC_F
                                                : sram_timing_pkg::REC_CYC_S);
   localparam int RD_VALID = 2 + (FAST_GRADE ? sram_timing_pkg::READ_CYC_F
                                             : sram_timing_pkg::READ_CYC_S);
   logic [7:0] low_len;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Write pulse length in cycles
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || write_en_n_o) begin
         low_len <= 8'h00;
      end else begin
         low_len <= low_len + 8'h01;
      end
   end
   property p_rd_take;
      ce_i && ready_o && req_i && !req_write_i |=> !chip_sel_n_o && !out_en_n_o && write_en_n_o
         && word_address_o == $past(req_addr_i);
   endproperty
   a_rd_take: assert property (p_rd_take) else $error("read not started");
   property p_rd_len;
      $fell(out_en_n_o) |=> (!chip_sel_n_o && !out_en_n_o && $stable(word_address_o))[*3];
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read cycle too short");
   property p_rd_valid;
      $fell(out_en_n_o) |-> ##[RD_VALID:RD_VALID] (rvalid_o && $rose(out_en_n_o)) ##1 done_o;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read data timing");
   property p_wr_take;
      ce_i && ready_o && req_i && req_write_i |=> $fell(write_en_n_o) && $fell(chip_sel_n_o)
         && out_en_n_o && shared_data_bus_oe_o && word_address_o == $past(req_addr_i)
         && shared_data_bus_o == $past(req_wdata_i);
   endproperty
   a_wr_take: assert property (p_wr_take) else $error("write start wrong");
   property p_wr_pulse;
      $rose(write_en_n_o) |-> low_len == PULSE && $rose(chip_sel_n_o);
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length");
   property p_wr_hold;
      !write_en_n_o |=> shared_data_bus_oe_o && $stable(shared_data_bus_o)
         && $stable(word_address_o);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data or address moved");
   property p_wr_cycle;
      $fell(write_en_n_o) |-> ##[WR_DONE:WR_DONE] (done_o && ready_o);
   endproperty
   a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle length");
   property p_no_fight;
      shared_data_bus_oe_o |-> out_en_n_o && $past(out_en_n_o);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus driven during read");
   c_read: cover property (rvalid_o);
   c_write: cover property ($rose(write_en_n_o));
   c_chain: cover property (done_o ##1 $fell(write_en_n_o));
endmodule : sram_host_ctrl_chk
bind sram_host_ctrl sram_host_ctrl_chk #(.FAST_GRADE(FAST_GRADE)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .req_write_i(req_write_i),
   .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o), .done_o(done_o),
   .rvalid_o(rvalid_o), .word_address_o(word_address_o), .chip_sel_n_o(chip_sel_n_o),
   .out_en_n_o(out_en_n_o), .write_en_n_o(write_en_n_o),
   .shared_data_bus_o(shared_data_bus_o), .shared_data_bus_oe_o(shared_data_bus_oe_o));

// [test/sram_model.sv]
`timescale 1ns/100ps
module sram_model #(
   parameter int ACCESS_NS = 55,
   parameter int FLOAT_NS  = 20
) (
   input  wire logic [18:0] word_address_i,
   input  wire logic        chip_sel_n_i,
   input  wire logic        out_en_n_i,
   input  wire logic        write_en_n_i,
   input  wire logic [7:0]  bus_i,
   output logic [7:0]       data_o,
   output logic             drive_o
);
   logic [7:0] mem [logic [18:0]];
   logic       rd_on;
   logic       wr_on;
   assign rd_on = !chip_sel_n_i && !out_en_n_i && write_en_n_i;
   assign wr_on = !chip_sel_n_i && !write_en_n_i;
   function automatic logic [7:0] rd_val(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction : rd_val
   initial begin
      drive_o = 1'b0;
      data_o = 8'h00;
   end
   // ----------------------------------------------------------------
   // Outputs turn on as early and float as late as the limits allow
   // ----------------------------------------------------------------
   always @(rd_on) begin
      if (rd_on) begin
         drive_o <= #10 1'b1;
      end else begin
         drive_o <= #FLOAT_NS 1'b0;
      end
   end
   // Junk after the hold time, so an early sample reads wrong
   always @(rd_on or word_address_i) begin
      data_o <= #10 ~rd_val(word_address_i);
      data_o <= #ACCESS_NS rd_val(word_address_i);
   end
   always @(negedge wr_on) begin
      mem[word_address_i] = bus_i;
   end
endmodule : sram_model

// [test/test_async_sram_access_timing.sv]
`timescale 1ns/100ps
`define CHK(what, exp, got) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
   end \
end
module test_async_sram_access_timing;
   localparam int WR_LAT = sram_timing_pkg::PULSE_CYC_F + sram_timing_pkg::REC_CYC_F;
   localparam int RD_LAT = sram_timing_pkg::READ_CYC_F + 2 + sram_timing_pkg::FLOAT_CYC_F;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   logic        ce = 1'b1;
   logic        req_wr = 1'b0;
   logic [18:0] req_addr = 19'h00000;
   logic [7:0]  req_data = 8'h00;
   logic [7:0]  float_pat = 8'h81;
   logic        ready, done, rvalid, cs_n, oe_n, we_n, bus_oe, mem_drive;
   logic [7:0]  rdata, bus_out, bus, mem_data, rd;
   logic [18:0] addr;
   int          num_errors = 0;
   int          n_checks = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) float_pat <= ~float_pat;
   // Nobody driving: a changing pattern, never the last value
   assign bus = bus_oe ? bus_out : (mem_drive ? mem_data : float_pat);
   sram_host_ctrl #(.FAST_GRADE(1'b1)) u_dut (
      .clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req), .req_write_i(req_wr),
      .req_addr_i(req_addr), .req_wdata_i(req_data), .ready_o(ready), .done_o(done),
      .rvalid_o(rvalid), .rdata_o(rdata), .word_address_o(addr), .chip_sel_n_o(cs_n),
      .out_en_n_o(oe_n), .write_en_n_o(we_n), .shared_data_bus_o(bus_out),
      .shared_data_bus_oe_o(bus_oe), .shared_data_bus_i(bus));
   sram_model u_mem (.word_address_i(addr), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
      .write_en_n_i(we_n), .bus_i(bus), .data_o(mem_data), .drive_o(mem_drive));
   always @(posedge clk) begin
      if (mem_drive && bus_oe) begin
         num_errors++;
         $display("ERROR bus contention expected 0 seen 1");
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   task automatic drive(input logic wr, input logic [18:0] a, input logic [7:0] d);
      @(negedge clk);
      req_wr = wr;
      req_addr = a;
      req_data = d;
      req = 1'b1;
   endtask : drive
   task automatic wait_take();
      int i;
      for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
      `CHK("request taken", 1'b1, ready)
      if (ready !== 1'b1) wrap_up();
      @(posedge clk);
   endtask : wait_take
   task automatic xfer(input logic wr, input logic [18:0] a, input logic [7:0] d,
                       output logic [7:0] got);
      int lat;
      int rv;
      got = 8'h00;
      rv = 0;
      drive(wr, a, d);
      wait_take();
      @(negedge clk);
      req = 1'b0;
      for (lat = 1; lat < 20; lat++) begin
         @(posedge clk);
         #1;
         if (rvalid === 1'b1) begin
            got = rdata;
            rv = lat;
         end
         if (done === 1'b1) break;
      end
      `CHK("transfer cycles", wr ? WR_LAT : RD_LAT, lat)
      if (!wr) `CHK("rvalid cycle", RD_LAT - sram_timing_pkg::FLOAT_CYC_F, rv)
      if (lat == 20) wrap_up();
   endtask : xfer
   task automatic t_reset();
      repeat (5) @(negedge clk);
      `CHK("ready in reset", 1'b0, ready)
      `CHK("idle pins", 4'hE, {cs_n, oe_n, we_n, bus_oe})
      rst = 1'b0;
      @(posedge clk);
      #1;
      `CHK("ready after reset", 1'b1, ready)
   endtask : t_reset
   task automatic t_table();
      logic [18:0] a [4] = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555};
      logic [7:0]  d [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, a[i], d[i], rd);
         `CHK("stored byte", d[i], u_mem.mem[a[i]])
      end
      for (int i = 3; i >= 0; i--) begin
         xfer(1'b0, a[i], 8'h00, rd);
         `CHK("read byte", d[i], rd)
      end
   endtask : t_table
   task automatic t_turnaround();
      xfer(1'b0, 19'h7FFFF, 8'h00, rd);
      xfer(1'b1, 19'h7FFFF, 8'h3C, rd);
      xfer(1'b0, 19'h7FFFF, 8'h00, rd);
      `CHK("read after turnaround", 8'h3C, rd)
   endtask : t_turnaround
   task automatic t_refused();
      int n;
      n = 0;
      drive(1'b1, 19'h01234, 8'h11);
      wait_take();
      @(negedge clk);
      req_addr = 19'h04321;
      req_data = 8'h22;
      for (int i = 0; i < 20 && n < 2; i++) begin
         @(posedge clk);
         #1;
         if (done === 1'b1) n++;
      end
      @(negedge clk);
      req = 1'b0;
      `CHK("done pulses", 2, n)
      `CHK("first byte", 8'h11, u_mem.mem[19'h01234])
      `CHK("second byte", 8'h22, u_mem.mem[19'h04321])
   endtask : t_refused
   task automatic t_freeze();
      @(negedge clk);
      ce = 1'b0;
      drive(1'b0, 19'h2AAAA, 8'h00);
      repeat (3) @(negedge clk);
      `CHK("frozen pins", 4'hE, {cs_n, oe_n, we_n, bus_oe})
      req = 1'b0;
      ce = 1'b1;
      xfer(1'b0, 19'h2AAAA, 8'h00, rd);
      `CHK("read after freeze", 8'hA5, rd)
   endtask : t_freeze
   task automatic t_mid_reset();
      drive(1'b1, 19'h00100, 8'h77);
      wait_take();
      @(negedge clk);
      rst = 1'b1;
      req = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("pins in reset", 4'hE, {cs_n, oe_n, we_n, bus_oe})
      rst = 1'b0;
      xfer(1'b0, 19'h55555, 8'h00, rd);
      `CHK("read after reset", 8'h5A, rd)
   endtask : t_mid_reset
   initial begin
      t_reset();
      t_table();
      t_turnaround();
      t_refused();
      t_freeze();
      t_mid_reset();
      wrap_up();
   end
endmodule : test_async_sram_access_timing
